/* logic/tx_elastic_store.sv */
/*
  Transmit elastic store: serial system highway in, line transmitter bit out.
  Assumes the highway and line clock pins are asynchronous to clk_in and run far slower than it; the register port is on clk_in.
*/
// The address map and the plain strobed port are this design's own decisions.
// Contract
// RULE1: Store holds at most two frames of 193 bits each.
// RULE2: Size field: bypass, one frame, two frames, or 96-bit short buffer.
// RULE3: After a slip the delay is recentred to 96, 193 or 48 bits.
// RULE4: Overflow or underflow of the store counts as a transmit slip.
// RULE5: Positive and negative slips set two separate status flags.
// RULE6: Slip detection and correction run without software help.
// RULE7: Writes follow system clock and sync pulse plus programmed offset.
// RULE8: Reads use the dejittered or the external transmit clock.
// RULE9: Offset reprogramming reinitialises the store at the next sync pulse.
// RULE10: System clock rate chosen by two rate fields, times one to eight.
// RULE11: One control bit selects rising or falling system clock edge.
// RULE12: Three-bit phase selector picks the sampled channel phase.
// RULE13: Bypass keeps offsets without slips; short buffer drops offsets.
// RULE14: Short buffer at 2.048-based rates forces translation mode 0.
// RULE15: Loop-timed transmit needs the store enabled, not bypassed; the code only stores loop_timed and never checks it.
// RULE16: A slip repeats or drops one whole frame in two-frame mode.
`timescale 1ns/100ps
module tx_elastic_store (
  input  wire logic                          clk_in,
  input  wire logic                          rst_in,
  input  wire logic [tx_ebuf_pkg::ADDR_W-1:0] addr_in,
  input  wire logic [tx_ebuf_pkg::DATA_W-1:0] wr_data_in,
  input  wire logic                          wr_en_in,
  input  wire logic                          rd_en_in,
  output logic      [tx_ebuf_pkg::DATA_W-1:0] rd_data_out,
  input  wire logic                          sys_tx_clock_in,
  input  wire logic                          sys_tx_sync_pulse_in,
  input  wire logic                          sys_tx_data_in,
  input  wire logic                          tx_dejitter_oscillator_in,
  input  wire logic                          ext_tx_clock_in,
  output logic                               line_tx_data_out,
  output logic                               line_tx_clock_out
);
  import tx_ebuf_pkg::*;

  typedef struct packed {
    logic [1:0]          size;
    logic                edge_sel;
    logic [2:0]          phase_sel;
    logic [1:0]          rate_lo;
    logic                rate_hi;
    logic                xlat;
    logic                rd_clk_sel;
    logic                loop_timed;
    logic [8:0]          offset;
    logic                pos_flag;
    logic                neg_flag;
    logic                reinit;
    logic [2:0]          phase;
    logic [8:0]          pos;
    logic [8:0]          wp;
    logic [8:0]          rp;
    logic [8:0]          fill;
    logic [MEM_BITS-1:0] mem;
    logic                byp_bit;
    logic                line_data;
    logic                line_clk;
    logic [DATA_W-1:0]   rd_data;
  } state_s;

  state_s     s_reg;
  state_s     s_next;
  logic [4:0] pins_sync;
  logic [1:0] clk_rise;
  logic [1:0] clk_fall;
  logic       take;
  logic       sync_now;
  logic       wr_bit;
  logic       rd_bit;
  logic       ovf;
  logic       unf;
  logic [8:0] pos_now;

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic [8:0] depth_of(input logic [1:0] sz);
    if (sz == SIZE_TWO) begin
      depth_of = DEPTH_TWO;
    end else if (sz == SIZE_SHORT) begin
      depth_of = DEPTH_SHRT;
    end else begin
      depth_of = DEPTH_ONE;
    end
  endfunction

  function automatic logic [8:0] center_of(input logic [1:0] sz);
    if (sz == SIZE_TWO) begin
      center_of = CTR_TWO;
    end else if (sz == SIZE_SHORT) begin
      center_of = CTR_SHRT;
    end else begin
      center_of = CTR_ONE;
    end
  endfunction

  // Modular difference a - b within a buffer of depth d.
  function automatic logic [8:0] ptr_sub(input logic [8:0] a, input logic [8:0] b, input logic [8:0] d);
    logic [9:0] t;
    t = (a >= b) ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, d} - {1'b0, b};
    ptr_sub = t[8:0];
  endfunction

  function automatic logic [8:0] ptr_inc(input logic [8:0] a, input logic [8:0] d);
    ptr_inc = (a + 9'h001 >= d) ? 9'h000 : a + 9'h001;
  endfunction

  // ---------------------------------------------------------------------------
  // Pin capture
  // ---------------------------------------------------------------------------
  // Clock pins are sampled like data; the core clock must outrun them.
  pin_sync #(.WIDTH(5)) u_sync (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .pins_in  ({ext_tx_clock_in, tx_dejitter_oscillator_in, sys_tx_data_in,
                sys_tx_sync_pulse_in, sys_tx_clock_in}),
    .sync_out (pins_sync)
  );

  edge_finder #(.WIDTH(2)) u_edges (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .level_in ({s_reg.rd_clk_sel ? pins_sync[4] : pins_sync[3], pins_sync[0]}),
    .rise_out (clk_rise),
    .fall_out (clk_fall)
  );

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    logic [8:0] dep;
    logic [8:0] ctr;
    logic [8:0] frame;
    logic [8:0] start;
    logic [2:0] mask;
    logic       active;
    logic       mapped;
    logic [8:0] lpos;
    logic [8:0] wp_new;
    s_next = s_reg;
    dep    = depth_of(s_reg.size);
    ctr    = center_of(s_reg.size);
    frame  = s_reg.rate_hi ? E_FRAME : T1_FRAME;
    // Short buffer ignores the programmed offset.
    start  = (s_reg.size == SIZE_SHORT) ? 9'h000 : s_reg.offset; // RULE13
    mask   = 3'((4'h1 << s_reg.rate_lo) - 4'h1); // RULE10
    active = s_reg.edge_sel ? clk_fall[0] : clk_rise[0]; // RULE11
    // Only the selected channel phase of a multiplexed highway is sampled.
    take     = active && ((s_reg.phase & mask) == (s_reg.phase_sel & mask)); // RULE12
    sync_now = take && pins_sync[1]; // RULE7
    pos_now  = sync_now ? start : s_reg.pos; // RULE7
    // Translate the system slot layout onto the 193-bit line frame.
    lpos   = pos_now;
    mapped = 1'b1;
    if (s_reg.rate_hi) begin
      if (s_reg.xlat && (s_reg.size != SIZE_SHORT)) begin
        mapped = (pos_now == XL_FBIT) || ((pos_now >= XL_CH_LO) && (pos_now < XL_CH_HI));
        lpos   = (pos_now == XL_FBIT) ? 9'h000 : pos_now - XL_FBIT;
      end else begin
        mapped = pos_now < T1_FRAME; // RULE14
      end
    end
    wr_bit = take && mapped && (lpos < T1_FRAME) && (s_reg.size != SIZE_BYPASS); // RULE1
    rd_bit = clk_rise[1] && (s_reg.size != SIZE_BYPASS); // RULE8
    // Slips are suppressed in bypass and while a realignment is pending.
    ovf = wr_bit && !rd_bit && (s_reg.fill == dep) && !s_reg.reinit; // RULE4
    unf = rd_bit && !wr_bit && (s_reg.fill == 9'h000) && !s_reg.reinit; // RULE4

    // Phase and bit position along the system frame.
    if (active) begin
      s_next.phase = 3'((s_reg.phase + 3'h1) & mask);
      if ((s_reg.phase & mask) == mask) begin
        s_next.pos = (pos_now + 9'h001 >= frame) ? 9'h000 : pos_now + 9'h001;
      end else begin
        s_next.pos = pos_now;
      end
    end
    if (take && s_reg.size == SIZE_BYPASS) begin
      s_next.byp_bit = pins_sync[2];
    end

    // Store traffic.
    wp_new = s_reg.wp;
    if (wr_bit) begin
      s_next.mem[s_reg.wp] = pins_sync[2];
      wp_new               = ptr_inc(s_reg.wp, dep);
    end
    s_next.wp = wp_new;
    if (rd_bit) begin
      s_next.line_data = s_reg.mem[s_reg.rp]; // RULE8
      s_next.rp        = ptr_inc(s_reg.rp, dep);
    end else if (clk_rise[1]) begin
      s_next.line_data = s_reg.byp_bit;
    end
    // Fill is frozen while a realignment is pending; unguarded it would wrap past zero or past the depth.
    s_next.fill = s_reg.reinit ? s_reg.fill : s_reg.fill + {8'h00, wr_bit} - {8'h00, rd_bit};
    s_next.line_clk = s_reg.rd_clk_sel ? pins_sync[4] : pins_sync[3];

    // Slip: recentre the read pointer, which in two-frame mode repeats or drops one frame.
    if (ovf || unf) begin
      s_next.rp   = ptr_sub(wp_new, ctr, dep); // RULE3 RULE6 RULE16
      s_next.fill = ctr; // RULE3
    end
    // Reinitialise at the first sync pulse after reprogramming.
    if (s_reg.reinit && sync_now) begin
      s_next.reinit = 1'b0; // RULE9
      s_next.wp     = 9'h000;
      s_next.rp     = ptr_sub(9'h000, ctr, dep);
      s_next.fill   = ctr;
    end

    // Register port: writes.
    if (wr_en_in) begin
      if (addr_in == CTRL_OFS) begin
        s_next.size       = wr_data_in[CTRL_SIZE_LSB +: 2]; // RULE2
        s_next.edge_sel   = wr_data_in[CTRL_EDGE_BIT];
        s_next.phase_sel  = wr_data_in[CTRL_PHASE_LSB +: 3];
        s_next.rate_lo    = wr_data_in[CTRL_RLO_LSB +: 2];
        s_next.rate_hi    = wr_data_in[CTRL_RHI_BIT];
        s_next.xlat       = wr_data_in[CTRL_XLAT_BIT];
        s_next.rd_clk_sel = wr_data_in[CTRL_RDCLK_BIT];
        s_next.loop_timed = wr_data_in[CTRL_LOOP_BIT]; // RULE15
        if (wr_data_in[CTRL_SIZE_LSB +: 2] != s_reg.size) begin
          s_next.reinit = 1'b1;
        end
      end else if (addr_in == OFFSET_OFS) begin
        s_next.offset = wr_data_in[8:0];
        s_next.reinit = 1'b1; // RULE9
      end
    end
    // Flags: a slip in the clearing cycle wins over the clear.
    s_next.pos_flag = s_reg.pos_flag;
    s_next.neg_flag = s_reg.neg_flag;
    if (wr_en_in && addr_in == STATUS_OFS) begin
      s_next.pos_flag = s_reg.pos_flag & ~wr_data_in[STAT_POS_BIT];
      s_next.neg_flag = s_reg.neg_flag & ~wr_data_in[STAT_NEG_BIT];
    end
    if (ovf) begin
      s_next.pos_flag = 1'b1; // RULE5
    end
    if (unf) begin
      s_next.neg_flag = 1'b1; // RULE5
    end

    // Register port: reads answer one cycle later, zero otherwise.
    s_next.rd_data = '0;
    if (rd_en_in) begin
      if (addr_in == CTRL_OFS) begin
        s_next.rd_data = {20'h0_0000, s_reg.loop_timed, s_reg.rd_clk_sel, s_reg.xlat, s_reg.rate_hi,
                          s_reg.rate_lo, s_reg.phase_sel, s_reg.edge_sel, s_reg.size};
      end else if (addr_in == OFFSET_OFS) begin
        s_next.rd_data = {23'h00_0000, s_reg.offset};
      end else if (addr_in == STATUS_OFS) begin
        s_next.rd_data = {15'h0000, s_reg.fill, 5'h00, s_reg.reinit, s_reg.neg_flag, s_reg.pos_flag};
      end
    end
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  // Reset leaves a realignment pending so no slip fires before the first sync.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_reg        <= '0;
      s_reg.size   <= SIZE_RST;
      s_reg.reinit <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rd_data_out       = s_reg.rd_data;
  assign line_tx_data_out  = s_reg.line_data;
  assign line_tx_clock_out = s_reg.line_clk;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  property p_fill_bound;
    @(posedge clk_in) disable iff (rst_in) s_reg.fill <= DEPTH_TWO;
  endproperty
  a_fill_bound: assert property (p_fill_bound) else $error("fill above two frames"); // RULE1

  property p_short_fill;
    @(posedge clk_in) disable iff (rst_in)
      (s_reg.size == SIZE_SHORT && !s_reg.reinit && $stable(s_reg.size)) |-> s_reg.fill <= DEPTH_SHRT;
  endproperty
  a_short_fill: assert property (p_short_fill) else $error("short buffer overfilled"); // RULE2

  property p_recentre;
    @(posedge clk_in) disable iff (rst_in)
      (ovf || unf) |=> s_reg.fill == center_of($past(s_reg.size));
  endproperty
  a_recentre: assert property (p_recentre) else $error("slip did not recentre"); // RULE3

  property p_pos_slip;
    @(posedge clk_in) disable iff (rst_in) ovf |=> s_reg.pos_flag ##1 (s_reg.pos_flag || $past(wr_en_in));
  endproperty
  a_pos_slip: assert property (p_pos_slip) else $error("overflow not flagged"); // RULE4

  property p_neg_slip;
    @(posedge clk_in) disable iff (rst_in) unf |=> s_reg.neg_flag && !$past(ovf);
  endproperty
  a_neg_slip: assert property (p_neg_slip) else $error("underflow not flagged"); // RULE5

  property p_offset_reinit;
    @(posedge clk_in) disable iff (rst_in) (wr_en_in && addr_in == OFFSET_OFS) |=> s_reg.reinit;
  endproperty
  a_offset_reinit: assert property (p_offset_reinit) else $error("offset write left no reinit"); // RULE9

  property p_bypass_quiet;
    @(posedge clk_in) disable iff (rst_in) (s_reg.size == SIZE_BYPASS) |-> !(ovf || unf || wr_bit || rd_bit);
  endproperty
  a_bypass_quiet: assert property (p_bypass_quiet) else $error("bypass touched the store"); // RULE13

  property p_short_map;
    @(posedge clk_in) disable iff (rst_in)
      (wr_bit && s_reg.size == SIZE_SHORT && s_reg.rate_hi) |-> pos_now < T1_FRAME;
  endproperty
  a_short_map: assert property (p_short_map) else $error("short buffer used mode 1"); // RULE14

  property p_frame_slip;
    @(posedge clk_in) disable iff (rst_in)
      (s_reg.size == SIZE_TWO && (ovf || unf)) |=> ptr_sub(s_reg.wp, s_reg.rp, DEPTH_TWO) == CTR_TWO;
  endproperty
  a_frame_slip: assert property (p_frame_slip) else $error("slip not one whole frame"); // RULE16

endmodule

/* logic/tx_ebuf_pkg.sv */
/*
  Constants shared by the transmit elastic store: register offsets, field
  positions, reset values, buffer sizes and frame geometry.
  Assumes a 32-bit register port with byte offsets and a 20 MHz core clock.
*/
package tx_ebuf_pkg;

  // ---------------------------------------------------------------------------
  // Register port and map
  // ---------------------------------------------------------------------------
  localparam int         ADDR_W     = 8;
  localparam int         DATA_W     = 32;
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] OFFSET_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;

  // Control register fields.
  localparam int CTRL_SIZE_LSB  = 0;
  localparam int CTRL_EDGE_BIT  = 2;
  localparam int CTRL_PHASE_LSB = 3;
  localparam int CTRL_RLO_LSB   = 6;
  localparam int CTRL_RHI_BIT   = 8;
  localparam int CTRL_XLAT_BIT  = 9;
  localparam int CTRL_RDCLK_BIT = 10;
  localparam int CTRL_LOOP_BIT  = 11;

  // Status register fields.
  localparam int STAT_POS_BIT    = 0;
  localparam int STAT_NEG_BIT    = 1;
  localparam int STAT_REINIT_BIT = 2;
  localparam int STAT_FILL_LSB   = 8;

  // ---------------------------------------------------------------------------
  // Buffer geometry
  // ---------------------------------------------------------------------------
  localparam logic [1:0] SIZE_BYPASS = 2'h0;
  localparam logic [1:0] SIZE_ONE    = 2'h1;
  localparam logic [1:0] SIZE_TWO    = 2'h2;
  localparam logic [1:0] SIZE_SHORT  = 2'h3;
  localparam logic [1:0] SIZE_RST    = 2'h1;

  localparam int         PTR_W      = 9;
  localparam int         MEM_BITS   = 386;
  localparam logic [8:0] DEPTH_ONE  = 9'h0c1;
  localparam logic [8:0] DEPTH_TWO  = 9'h182;
  localparam logic [8:0] DEPTH_SHRT = 9'h060;
  localparam logic [8:0] CTR_ONE    = 9'h060;
  localparam logic [8:0] CTR_TWO    = 9'h0c1;
  localparam logic [8:0] CTR_SHRT   = 9'h030;

  // System frame lengths and the mode 1 translation points.
  localparam logic [8:0] T1_FRAME   = 9'h0c1;
  localparam logic [8:0] E_FRAME    = 9'h100;
  localparam logic [8:0] XL_FBIT    = 9'h007;
  localparam logic [8:0] XL_CH_LO   = 9'h008;
  localparam logic [8:0] XL_CH_HI   = 9'h0c8;

endpackage

/* logic/pin_sync.sv */
/*
  Two-stage synchroniser for a group of asynchronous pins.
  Assumes a single core clock; only the second stage may be read outside.
*/
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic [WIDTH-1:0] pins_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] held;
  } sync_s;

  sync_s s_reg;
  sync_s s_next;

  // ---------------------------------------------------------------------------
  // Stages
  // ---------------------------------------------------------------------------
  // The first stage feeds only the second one, never any logic.
  always_comb begin
    s_next.meta = pins_in;
    s_next.held = s_reg.meta;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign sync_out = s_reg.held;

endmodule

/* logic/edge_finder.sv */
/*
  Edge detector for already synchronised levels: one-cycle rise and fall pulses.
  Assumes its inputs are on the core clock.
*/
`timescale 1ns/100ps
module edge_finder #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic [WIDTH-1:0] level_in,
  output logic      [WIDTH-1:0] rise_out,
  output logic      [WIDTH-1:0] fall_out
);

  typedef struct packed {
    logic [WIDTH-1:0] last;
  } edge_s;

  edge_s s_reg;
  edge_s s_next;

  // ---------------------------------------------------------------------------
  // Detection
  // ---------------------------------------------------------------------------
  // Pulses are combinational so the caller sees them beside the new level.
  always_comb begin
    s_next.last = level_in;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rise_out = level_in & ~s_reg.last;
  assign fall_out = ~level_in & s_reg.last;

endmodule

/* bench/sys_highway_model.sv */
/*
  Behavioural system backplane: drives the serial highway clock, frame sync and data.
  Assumes one bit per system clock period and data sampled on the rising edge.
*/
`timescale 1ns/100ps
module sys_highway_model #(
  parameter realtime HALF_NS = 200.0
) (
  input  wire logic run_in,
  output logic      sys_tx_clock_out,
  output logic      sys_tx_sync_pulse_out,
  output logic      sys_tx_data_out
);
  // ---------------------------------------------------------------------------
  // Highway generator
  // ---------------------------------------------------------------------------
  int unsigned bit_pos;
  int unsigned frame_cnt;

  initial begin
    sys_tx_clock_out      = 1'b0;
    sys_tx_sync_pulse_out = 1'b0;
    sys_tx_data_out       = 1'b0;
    bit_pos               = 192;
    frame_cnt             = 0;
  end

  // New bits launch on the falling edge so they are stable at the rising one.
  always begin
    #(HALF_NS);
    if (run_in) begin
      sys_tx_clock_out = ~sys_tx_clock_out;
      if (!sys_tx_clock_out) begin
        bit_pos = (bit_pos == 192) ? 0 : bit_pos + 1;
        if (bit_pos == 0) begin
          frame_cnt = frame_cnt + 1;
        end
        sys_tx_sync_pulse_out = (bit_pos == 0);
        sys_tx_data_out       = ^(bit_pos[7:0] & 8'h5b) ^ frame_cnt[0];
      end
    end
  end
endmodule

/* bench/tb_t1_transmit_elastic_buffer.sv */
/*
  Self-checking bench for the transmit elastic store.
  Assumes the highway model on the system side and bench-made read clocks.
*/
`timescale 1ns/100ps
module tb_t1_transmit_elastic_buffer;
  import tx_ebuf_pkg::*;

  // ---------------------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------------------
  logic              clk_in;
  logic              rst_in;
  logic [ADDR_W-1:0] addr_in;
  logic [DATA_W-1:0] wr_data_in;
  logic              wr_en_in;
  logic              rd_en_in;
  logic [DATA_W-1:0] rd_data_out;
  logic [DATA_W-1:0] rd_word;
  logic              sys_clk;
  logic              sys_sync;
  logic              sys_data;
  logic              dj_clk;
  logic              ext_clk;
  logic              dj_run;
  logic              ext_run;
  logic              line_data;
  logic              line_clk;
  logic              line_prev;
  logic [511:0]      sys_hist;
  logic [63:0]       line_hist;
  realtime           dj_half;
  realtime           ext_half;
  int                mismatches;
  int                comparisons;

  // ---------------------------------------------------------------------------
  // Clocks and instances
  // ---------------------------------------------------------------------------
  initial begin
    clk_in      = 1'b0;
    rst_in      = 1'b1;
    addr_in     = 8'h00;
    wr_data_in  = 32'h0000_0000;
    wr_en_in    = 1'b0;
    rd_en_in    = 1'b0;
    dj_clk      = 1'b0;
    ext_clk     = 1'b0;
    dj_run      = 1'b1;
    ext_run     = 1'b1;
    dj_half     = 200.0;
    ext_half    = 180.0;
    mismatches  = 0;
    comparisons = 0;
    line_prev   = 1'b0;
    sys_hist    = '0;
    line_hist   = '0;
  end

  always #25 clk_in = ~clk_in;

  // Read clocks are free running and unrelated in phase to the core clock.
  always begin
    #(dj_half);
    if (dj_run) dj_clk = ~dj_clk;
  end
  always begin
    #(ext_half);
    if (ext_run) ext_clk = ~ext_clk;
  end

  // Highway bits are recorded at the rising system edge, where the model holds them stable.
  always @(posedge sys_clk) sys_hist = {sys_hist[510:0], sys_data};

  // Line bits are collected just after the core edge, once the output flops have settled.
  always @(posedge clk_in) begin
    #1;
    if (line_clk && !line_prev) begin
      line_hist = {line_hist[62:0], line_data};
    end
    line_prev = line_clk;
  end

  sys_highway_model #(.HALF_NS(200.0)) highway (
    .run_in               (1'b1),
    .sys_tx_clock_out     (sys_clk),
    .sys_tx_sync_pulse_out(sys_sync),
    .sys_tx_data_out      (sys_data)
  );

  tx_elastic_store DUT (
    .clk_in                   (clk_in),
    .rst_in                   (rst_in),
    .addr_in                  (addr_in),
    .wr_data_in               (wr_data_in),
    .wr_en_in                 (wr_en_in),
    .rd_en_in                 (rd_en_in),
    .rd_data_out              (rd_data_out),
    .sys_tx_clock_in          (sys_clk),
    .sys_tx_sync_pulse_in     (sys_sync),
    .sys_tx_data_in           (sys_data),
    .tx_dejitter_oscillator_in(dj_clk),
    .ext_tx_clock_in          (ext_clk),
    .line_tx_data_out         (line_data),
    .line_tx_clock_out        (line_clk)
  );

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    wr_en_in   <= 1'b1;
    addr_in    <= a;
    wr_data_in <= d;
    @(posedge clk_in);
    wr_en_in   <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample just after that edge.
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_in);
    rd_en_in <= 1'b1;
    addr_in  <= a;
    @(posedge clk_in);
    rd_en_in <= 1'b0;
    #1 d = rd_data_out;
  endtask

  // Fill may move a bit or two between sampling and reading, hence the margin.
  task automatic check_fill(input logic [31:0] st, input logic [8:0] centre);
    logic ok;
    ok = (st[16:8] + 9'h004 >= centre) && (st[16:8] <= centre + 9'h004);
    check({31'h0, ok}, 32'h0000_0001);
  endtask

  // The last 64 line bits must equal a run of highway bits, delayed by anything from 0 to 447 bits.
  function automatic logic stream_ok;
    stream_ok = 1'b0;
    for (int d = 0; d < 448; d++) begin
      if (sys_hist[d +: 64] == line_hist) stream_ok = 1'b1;
    end
  endfunction

  task automatic complete_run;
    $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic reset_values;
    reg_rd(CTRL_OFS, rd_word);
    check(rd_word, 32'h0000_0001);
    reg_rd(OFFSET_OFS, rd_word);
    check(rd_word, 32'h0000_0000);
    reg_rd(STATUS_OFS, rd_word);
    check({29'h0, rd_word[2:0]}, 32'h0000_0004);
    reg_wr(8'h0c, 32'h0000_0003);
    reg_rd(8'h0c, rd_word);
    check(rd_word, 32'h0000_0000);
    reg_rd(CTRL_OFS, rd_word);
    check(rd_word, 32'h0000_0001);
  endtask

  // An offset write must hold the store until the next sync, then restart centred.
  task automatic offset_reinit;
    repeat (3200) @(posedge clk_in);
    reg_rd(STATUS_OFS, rd_word);
    check({29'h0, rd_word[2:0]}, 32'h0000_0000);
    reg_wr(OFFSET_OFS, 32'h0000_0005);
    reg_rd(STATUS_OFS, rd_word);
    check({31'h0, rd_word[2]}, 32'h0000_0001);
    reg_rd(OFFSET_OFS, rd_word);
    check(rd_word, 32'h0000_0005);
    repeat (3200) @(posedge clk_in);
    reg_rd(STATUS_OFS, rd_word);
    check({29'h0, rd_word[2:0]}, 32'h0000_0000);
    check_fill(rd_word, CTR_ONE);
    check({31'h0, stream_ok()}, 32'h0000_0001);
  endtask

  // Sampling on the falling system edge must still carry the highway stream unbroken.
  task automatic falling_edge_path;
    reg_wr(CTRL_OFS, 32'h0000_0005);
    repeat (3200) @(posedge clk_in);
    check({31'h0, stream_ok()}, 32'h0000_0001);
    reg_rd(STATUS_OFS, rd_word);
    check({29'h0, rd_word[2:0]}, 32'h0000_0000);
    reg_rd(CTRL_OFS, rd_word);
    check(rd_word, 32'h0000_0005);
  endtask

  // Detune the read clock until a slip is flagged, then check flag and fill.
  task automatic run_slip(input logic [31:0] ctrl, input realtime half, input int b, input logic [8:0] centre);
    logic seen;
    seen    = 1'b0;
    dj_half = 200.0;
    reg_wr(CTRL_OFS, ctrl);
    reg_wr(STATUS_OFS, 32'h0000_0003);
    repeat (3200) @(posedge clk_in);
    dj_half = half;
    repeat (300) begin
      if (!seen) begin
        repeat (100) @(posedge clk_in);
        reg_rd(STATUS_OFS, rd_word);
        seen = rd_word[b];
      end
    end
    dj_half = 200.0;
    check({31'h0, seen}, 32'h0000_0001);
    check({31'h0, rd_word[1-b]}, 32'h0000_0000);
    check_fill(rd_word, centre);
    reg_wr(STATUS_OFS, 32'h0000_0003);
    reg_rd(STATUS_OFS, rd_word);
    check({30'h0, rd_word[1:0]}, 32'h0000_0000);
  endtask

  // Bypass on the external clock: no slips despite the rate gap, clock follows.
  task automatic bypass_ext_clock;
    int   n;
    logic prev;
    n       = 0;
    prev    = line_clk;
    dj_run  = 1'b0;
    reg_wr(CTRL_OFS, 32'h0000_0400);
    reg_wr(STATUS_OFS, 32'h0000_0003);
    repeat (4000) @(posedge clk_in);
    reg_rd(STATUS_OFS, rd_word);
    check({30'h0, rd_word[1:0]}, 32'h0000_0000);
    repeat (1600) begin
      @(posedge clk_in);
      #1;
      if (line_clk && !prev) n++;
      prev = line_clk;
    end
    check({31'h0, (n >= 221 && n <= 224)}, 32'h0000_0001);
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    reset_values();
    offset_reinit();
    falling_edge_path();
    run_slip(32'h0000_0001, 220.0, 0, CTR_ONE);
    run_slip(32'h0000_0003, 180.0, 1, CTR_SHRT);
    run_slip(32'h0000_0802, 220.0, 0, CTR_TWO);
    bypass_ext_clock();
    complete_run();
  end

  // Scenarios need about 60000 cycles; anything near the run limit is a hang.
  initial begin
    repeat (95000) @(posedge clk_in);
    mismatches++;
    complete_run();
  end
endmodule
